/* design/ndt_top.sv */
// Network-side layer 1 maintenance: defect actions and activation persistence timers.
// Assumes defect inputs come from line logic on another clock and are synchronised here.
//
// Overview of operation
// - Non-operational signal must persist the deactivation time before deactivate indication; here the window can close up to 1 ms short.
// - Operational frames must persist the activation time before activate indication; here the window can close up to 1 ms short.
// - Deactivation timer holds while activation timer runs, resumes when it clears.
// - Deactivation timer clears when the activation timer expires.
// - Activation timer clears on any non-operational signal.
// - Alarm outputs drop as soon as their causes go away.
// - Network power loss sends alarm indication signal only.
// - Signal loss sends remote alarm, CRC info only while still aligned.
// - Frame alignment loss sends remote alarm; CRC info is optional.
// - Network-to-user defect sends alarm indication signal only.
// - Received remote alarm generates nothing; CRC errors still reported.
// - User-to-network defect up to exchange termination sends remote alarm only.
// - Own detected CRC errors send CRC error information only.
// - Received CRC error information generates nothing.
// - Optionally send remote alarm on excessive CRC error ratio.
// - Detect power, signal, alignment, CRC defects and received indications.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps

module ndt_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_power_loss,
  input wire logic i_signal_loss,
  input wire logic i_align_loss,
  input wire logic i_crc_error,
  input wire logic i_rx_rai,
  input wire logic i_rx_crc_info,
  input wire logic i_net_user_defect,
  input wire logic i_user_net_defect,
  input wire logic i_excess_crc,
  input wire logic i_normal_frames,
  output logic o_tx_rai,
  output logic o_tx_ais,
  output logic o_tx_crc_info,
  output logic o_phys_activate_indication,
  output logic o_phys_deactivate_indication,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all line-side inputs.

  localparam int NIN = 10;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_normal_frames, i_excess_crc, i_user_net_defect, i_net_user_defect, i_rx_crc_info,
                    i_rx_rai, i_crc_error, i_align_loss, i_signal_loss, i_power_loss};
      sync2_reg <= sync1_reg;
    end
  end

  logic power_loss;
  logic signal_loss;
  logic align_loss;
  logic crc_error;
  logic rx_rai;
  logic rx_crc_info;
  logic net_user_defect;
  logic user_net_defect;
  logic excess_crc;
  logic normal_frames;
  assign power_loss = sync2_reg[0];
  assign signal_loss = sync2_reg[1];
  assign align_loss = sync2_reg[2];
  assign crc_error = sync2_reg[3];
  assign rx_rai = sync2_reg[4];
  assign rx_crc_info = sync2_reg[5];
  assign net_user_defect = sync2_reg[6];
  assign user_net_defect = sync2_reg[7];
  assign excess_crc = sync2_reg[8];
  assign normal_frames = sync2_reg[9];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [1:0] ctrl_reg;
  logic [9:0] deact_ms_reg;
  logic [9:0] act_ms_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_stat_reg;
  logic wr_ok;
  logic rd_ok;
  // A write lands only at the edge where the master sees waitrequest low, which ends the transfer.
  assign wr_ok = i_avs_write && !i_avs_read && !o_avs_waitrequest;
  assign rd_ok = i_avs_read && !i_avs_write && o_avs_waitrequest;

  // Out-of-range writes are clamped so the persistence windows can never leave their permitted range.
  function automatic logic [9:0] clamp_ms(input logic [31:0] v, input int unsigned lo, input int unsigned hi);
    if (v < lo) begin
      clamp_ms = 10'(lo);
    end else if (v > hi) begin
      clamp_ms = 10'(hi);
    end else begin
      clamp_ms = v[9:0];
    end
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_reg <= ndt_pkg::CTRL_RESET;
      deact_ms_reg <= ndt_pkg::DEACT_RESET_MS;
      act_ms_reg <= ndt_pkg::ACT_RESET_MS;
      irq_mask_reg <= 3'h0;
    end else if (wr_ok) begin
      case (i_avs_address)
        ndt_pkg::ADDR_CTRL: begin
          ctrl_reg <= i_avs_writedata[1:0];
        end
        ndt_pkg::ADDR_DEACT: begin
          deact_ms_reg <= clamp_ms(i_avs_writedata, ndt_pkg::DEACT_MIN_MS, ndt_pkg::DEACT_MAX_MS);
        end
        ndt_pkg::ADDR_ACT: begin
          act_ms_reg <= clamp_ms(i_avs_writedata, ndt_pkg::ACT_MIN_MS, ndt_pkg::ACT_MAX_MS);
        end
        ndt_pkg::ADDR_IRQ_MASK: begin
          irq_mask_reg <= i_avs_writedata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick.

  // The divider runs free, so the first tick of a window may come early: a window can close up to 1 ms short.
  logic [14:0] div_reg;
  logic tick;
  assign tick = (div_reg == 15'(ndt_pkg::TICK_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_reg <= 15'h0;
    end else if (tick) begin
      div_reg <= 15'h0;
    end else begin
      div_reg <= div_reg + 15'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Persistence timers.

  ndt_pkg::ndt_state_t state_reg;
  logic [9:0] deact_cnt_reg;
  logic [9:0] act_cnt_reg;
  logic act_expire;
  logic deact_expire;
  logic active;
  logic arming_allowed;

  // True on the tick that completes a persistence window of lim_ms milliseconds.
  function automatic logic window_done(input logic [9:0] cnt, input logic [9:0] lim_ms);
    window_done = ({1'b0, cnt} + 11'h1) >= {1'b0, lim_ms};
  endfunction

  assign active = (state_reg == ndt_pkg::NDT_UP) || (state_reg == ndt_pkg::NDT_DISARMING);
  // The activation timer also runs while disarming, so returning frames can call off a pending deactivation.
  assign arming_allowed = (state_reg != ndt_pkg::NDT_UP);
  assign act_expire = normal_frames && arming_allowed && tick && window_done(act_cnt_reg, act_ms_reg);
  assign deact_expire = !normal_frames && (state_reg == ndt_pkg::NDT_DISARMING) && tick
                        && window_done(deact_cnt_reg, deact_ms_reg);

  // Activation timer runs only on operational frames and restarts on anything else.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      act_cnt_reg <= 10'h0;
    end else if (!normal_frames) begin
      act_cnt_reg <= 10'h0;
    end else if (act_expire) begin
      act_cnt_reg <= 10'h0;
    end else if (tick && arming_allowed) begin
      act_cnt_reg <= act_cnt_reg + 10'h1;
    end
  end

  // Deactivation timer holds its count while frames are being verified, so a short burst cannot restart it.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      deact_cnt_reg <= 10'h0;
    end else if (act_expire) begin
      deact_cnt_reg <= 10'h0;
    end else if (normal_frames) begin
      deact_cnt_reg <= deact_cnt_reg;
    end else if (deact_expire) begin
      deact_cnt_reg <= 10'h0;
    end else if (tick && state_reg == ndt_pkg::NDT_DISARMING) begin
      deact_cnt_reg <= deact_cnt_reg + 10'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg <= ndt_pkg::NDT_DOWN;
    end else begin
      case (state_reg)
        ndt_pkg::NDT_DOWN: begin
          if (normal_frames) begin
            state_reg <= ndt_pkg::NDT_ARMING;
          end
        end
        ndt_pkg::NDT_ARMING: begin
          if (!normal_frames) begin
            state_reg <= ndt_pkg::NDT_DOWN;
          end else if (act_expire) begin
            state_reg <= ndt_pkg::NDT_UP;
          end
        end
        ndt_pkg::NDT_UP: begin
          if (!normal_frames) begin
            state_reg <= ndt_pkg::NDT_DISARMING;
          end
        end
        ndt_pkg::NDT_DISARMING: begin
          // Returning frames must outlast the activation window before the deactivation is called off.
          if (act_expire) begin
            state_reg <= ndt_pkg::NDT_UP;
          end else if (deact_expire) begin
            state_reg <= ndt_pkg::NDT_DOWN;
          end
        end
        default: begin
          state_reg <= ndt_pkg::NDT_DOWN;
        end
      endcase
    end
  end

  logic act_pulse;
  logic deact_pulse;
  assign act_pulse = (state_reg == ndt_pkg::NDT_ARMING) && normal_frames && act_expire;
  assign deact_pulse = (state_reg == ndt_pkg::NDT_DISARMING) && !normal_frames && deact_expire;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_phys_activate_indication <= 1'b0;
      o_phys_deactivate_indication <= 1'b0;
    end else begin
      o_phys_activate_indication <= act_pulse;
      o_phys_deactivate_indication <= deact_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Consequent actions, recomputed every cycle so indications drop at once.
  // Received remote alarm and received CRC information add no term of their own.

  // Power loss overrides every other cause, since only the alarm indication signal can still be sent then.
  logic rai_next;
  logic ais_next;
  logic crc_next;
  always_comb begin
    ais_next = power_loss || net_user_defect;
    rai_next = !power_loss && (signal_loss || align_loss || user_net_defect
               || (ctrl_reg[ndt_pkg::CTRL_EXC_RAI] && excess_crc));
    // Frames carrying a received remote alarm still report their CRC errors.
    crc_next = !power_loss && !net_user_defect && !user_net_defect
               && ((crc_error && !align_loss)
               || (signal_loss && !align_loss)
               || (align_loss && ctrl_reg[ndt_pkg::CTRL_LFA_CRC]));
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_tx_rai <= 1'b0;
      o_tx_ais <= 1'b0;
      o_tx_crc_info <= 1'b0;
    end else begin
      o_tx_rai <= rai_next;
      o_tx_ais <= ais_next;
      o_tx_crc_info <= crc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status; a read clears it, but a new event in that cycle wins.

  logic [2:0] ev;
  logic [2:0] irq_stat_next;
  logic defect_now;
  logic defect_d_reg;
  logic stat_rd;
  assign defect_now = power_loss || signal_loss || align_loss || net_user_defect || user_net_defect || rx_rai;
  assign ev = {defect_now && !defect_d_reg, deact_pulse, act_pulse};
  assign stat_rd = rd_ok && (i_avs_address == ndt_pkg::ADDR_IRQ_STAT);
  // The clear and the set share one next value, so an event landing on the clearing read is never lost.
  assign irq_stat_next = (stat_rd ? 3'h0 : irq_stat_reg) | ev;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      defect_d_reg <= 1'b0;
    end else begin
      defect_d_reg <= defect_now;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // The level output follows the next status, so it rises in the same cycle as the status bit.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: waitrequest rests high and drops for one cycle to end each transfer.
  // Read data are loaded on the edge that first sees the request, so they already stand when the master
  // takes them; the price is one idle cycle per access, which the slow registers here can afford.

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (rd_ok) begin
      case (i_avs_address)
        ndt_pkg::ADDR_CTRL: begin
          o_avs_readdata <= {30'h0, ctrl_reg};
        end
        ndt_pkg::ADDR_DEACT: begin
          o_avs_readdata <= {22'h0, deact_ms_reg};
        end
        ndt_pkg::ADDR_ACT: begin
          o_avs_readdata <= {22'h0, act_ms_reg};
        end
        ndt_pkg::ADDR_STATE: begin
          o_avs_readdata <= {20'h0, act_cnt_reg == 10'h0, active, state_reg, 8'(sync2_reg)};
        end
        ndt_pkg::ADDR_IRQ_STAT: begin
          o_avs_readdata <= {29'h0, irq_stat_reg};
        end
        ndt_pkg::ADDR_IRQ_MASK: begin
          o_avs_readdata <= {29'h0, irq_mask_reg};
        end
        default: begin
          o_avs_readdata <= ndt_pkg::UNMAPPED_DATA;
        end
      endcase
    end
  end

endmodule

/* design/ndt_pkg.sv */
// Constants for the network-side defect action and persistence timer block.
// Assumes a 25 MHz system clock and an Avalon-MM register master.
package ndt_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEACT_MIN_MS = 100;
  localparam int unsigned DEACT_MAX_MS = 1000;
  localparam int unsigned ACT_MIN_MS = 10;
  localparam int unsigned ACT_MAX_MS = 100;
  localparam logic [9:0] DEACT_RESET_MS = 10'h1f4;
  localparam logic [9:0] ACT_RESET_MS = 10'h032;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DEACT = 4'h1;
  localparam logic [3:0] ADDR_ACT = 4'h2;
  localparam logic [3:0] ADDR_STATE = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam int CTRL_LFA_CRC = 0;
  localparam int CTRL_EXC_RAI = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int IRQ_ACT = 0;
  localparam int IRQ_DEACT = 1;
  localparam int IRQ_DEFECT = 2;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0;
  typedef enum logic [1:0] {
    NDT_DOWN = 2'b00,
    NDT_ARMING = 2'b01,
    NDT_UP = 2'b11,
    NDT_DISARMING = 2'b10
  } ndt_state_t;
endpackage

/* verif/ndt_top_monitor.sv */
// Concurrent checks on the defect action block, seen only through its top ports.
// Assumes one clock domain, synchronous active-low reset and the top port names.
`timescale 1ns/10ps

module ndt_top_monitor (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_power_loss,
  input wire logic i_signal_loss,
  input wire logic i_align_loss,
  input wire logic i_crc_error,
  input wire logic i_rx_rai,
  input wire logic i_rx_crc_info,
  input wire logic i_net_user_defect,
  input wire logic i_user_net_defect,
  input wire logic i_excess_crc,
  input wire logic i_normal_frames,
  input wire logic o_tx_rai,
  input wire logic o_tx_ais,
  input wire logic o_tx_crc_info,
  input wire logic o_phys_activate_indication
);
  logic [8:0] dv;
  logic [19:0] up_cnt;

  assign dv = {i_excess_crc, i_user_net_defect, i_net_user_defect, i_rx_crc_info, i_rx_rai, i_crc_error,
               i_align_loss, i_signal_loss, i_power_loss};

  ////////////////////////////////////////////////////////////////////////////////
  // Counts unbroken cycles of normal frames; it saturates so a long run never wraps.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !i_normal_frames) begin
      up_cnt <= 20'h0;
    end else if (up_cnt != 20'hfffff) begin
      up_cnt <= up_cnt + 20'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // Two sync stages and one output register give three cycles from cause to alarm.
  sequence s_tx3(r, a, c);
    ##3 (o_tx_rai == r && o_tx_ais == a && o_tx_crc_info == c);
  endsequence

  chk_power_ais: assert property (dv[0] |-> s_tx3(1'b0, 1'b1, 1'b0))
    else $error("power loss alarms wrong");
  chk_sigloss_rai: assert property (dv == 9'h002 |-> s_tx3(1'b1, 1'b0, 1'b1))
    else $error("signal loss alarms wrong");
  chk_align_rai: assert property (dv == 9'h00c |-> ##3 (o_tx_rai && !o_tx_ais))
    else $error("alignment loss alarms wrong");
  chk_netuser_ais: assert property (dv == 9'h040 |-> s_tx3(1'b0, 1'b1, 1'b0))
    else $error("network to user defect alarms wrong");
  chk_usernet_rai: assert property (dv == 9'h080 |-> s_tx3(1'b1, 1'b0, 1'b0))
    else $error("user to network defect alarms wrong");
  chk_own_crc: assert property (dv == 9'h008 || dv == 9'h018 |-> s_tx3(1'b0, 1'b0, 1'b1))
    else $error("crc error report wrong");
  chk_rx_quiet: assert property (dv == 9'h010 || dv == 9'h020 |-> s_tx3(1'b0, 1'b0, 1'b0))
    else $error("received indication answered");
  chk_clear_quiet: assert property (dv == 9'h000 |-> s_tx3(1'b0, 1'b0, 1'b0))
    else $error("alarm outlived its cause");
  chk_act_persist: assert property (o_phys_activate_indication |-> up_cnt >= 20'h36ee8)
    else $error("activate indication too early");
  chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule

bind ndt_top ndt_top_monitor ndt_top_monitor_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_power_loss(i_power_loss),
  .i_signal_loss(i_signal_loss), .i_align_loss(i_align_loss), .i_crc_error(i_crc_error), .i_rx_rai(i_rx_rai),
  .i_rx_crc_info(i_rx_crc_info), .i_net_user_defect(i_net_user_defect), .i_user_net_defect(i_user_net_defect),
  .i_excess_crc(i_excess_crc), .i_normal_frames(i_normal_frames), .o_tx_rai(o_tx_rai), .o_tx_ais(o_tx_ais),
  .o_tx_crc_info(o_tx_crc_info), .o_phys_activate_indication(o_phys_activate_indication));

/* verif/ndt_user_side.sv */
// Model of the user-side equipment: puts line conditions on the receive side.
// Assumes the bench hands it a condition word just after a rising edge.
`timescale 1ns/10ps

module ndt_user_side (
  input wire logic i_clock,
  input wire logic [9:0] i_cmd,
  output logic [9:0] o_line
);
  // Conditions change only on an edge, as a framed line would, so no glitch reaches the syncs.
  always_ff @(posedge i_clock) begin
    o_line <= i_cmd;
  end
endmodule

/* verif/network_side_defect_action_timers_tb.sv */
// Self-checking bench for the defect action and persistence timer block.
// Assumes the user-side model and the bound checker; the run covers about 17 ms.
`timescale 1ns/10ps

module network_side_defect_action_timers_tb;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  logic o_avs_waitrequest, o_tx_rai, o_tx_ais, o_tx_crc_info, o_phys_activate_indication;
  logic o_phys_deactivate_indication, o_irq;
  logic [9:0] cmd = 10'h0, line;
  logic [2:0] tx;
  int miscompares = 0, comparisons = 0, cyc = 0, t0 = 0, acts = 0, deacts = 0;
  // Each entry is control bits, expected remote alarm, alarm signal, crc report, then the defects.
  logic [13:0] tbl [14] = '{14'h0401, 14'h0a02, 14'h0a0a, 14'h080e, 14'h080c, 14'h1a0c, 14'h0440,
                            14'h0218, 14'h0880, 14'h0208, 14'h0020, 14'h0100, 14'h2900, 14'h0000};

  assign tx = {o_tx_rai, o_tx_ais, o_tx_crc_info};
  always #20 i_clock = ~i_clock;

  ndt_top ndt_top_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_power_loss(line[0]), .i_signal_loss(line[1]),
    .i_align_loss(line[2]), .i_crc_error(line[3]), .i_rx_rai(line[4]), .i_rx_crc_info(line[5]),
    .i_net_user_defect(line[6]), .i_user_net_defect(line[7]), .i_excess_crc(line[8]),
    .i_normal_frames(line[9]), .o_tx_rai(o_tx_rai), .o_tx_ais(o_tx_ais), .o_tx_crc_info(o_tx_crc_info),
    .o_phys_activate_indication(o_phys_activate_indication),
    .o_phys_deactivate_indication(o_phys_deactivate_indication), .o_irq(o_irq));
  ndt_user_side ndt_user_side_i (.i_clock(i_clock), .i_cmd(cmd), .o_line(line));

  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Only the bench timeout ends a wait for waitrequest.
  task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_avs_read <= rd;
    i_avs_write <= !rd;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clock);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    chk("register", q, e);
  endtask

  task line_set(input logic [9:0] c);
    @(posedge i_clock);
    cmd <= c;
    repeat (8) @(posedge i_clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // The tick is fixed at one millisecond, so the ceiling follows from the timer waits below.
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_phys_activate_indication === 1'b1) acts <= acts + 1;
    if (o_phys_deactivate_indication === 1'b1) deacts <= deacts + 1;
    if (cyc == 520000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(ndt_pkg::ADDR_CTRL, 32'h0);
    rd(ndt_pkg::ADDR_DEACT, 32'h1f4);
    rd(ndt_pkg::ADDR_ACT, 32'h32);
    rd(ndt_pkg::ADDR_IRQ_MASK, 32'h0);
    rd(4'hf, 32'h0);
    bus(1'b0, ndt_pkg::ADDR_DEACT, 32'h32);
    rd(ndt_pkg::ADDR_DEACT, 32'h64);
    bus(1'b0, ndt_pkg::ADDR_DEACT, 32'h7d0);
    rd(ndt_pkg::ADDR_DEACT, 32'h3e8);
    bus(1'b0, ndt_pkg::ADDR_ACT, 32'hc8);
    rd(ndt_pkg::ADDR_ACT, 32'h64);
    bus(1'b0, ndt_pkg::ADDR_ACT, 32'h5);
    rd(ndt_pkg::ADDR_ACT, 32'ha);
    bus(1'b0, ndt_pkg::ADDR_IRQ_MASK, 32'h4);
    line_set(10'h002);
    chk("irq raised", 32'(o_irq), 32'h1);
    rd(ndt_pkg::ADDR_IRQ_STAT, 32'h4);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 32'(o_irq), 32'h0);
    bus(1'b0, ndt_pkg::ADDR_IRQ_MASK, 32'h0);
    line_set(10'h000);
    line_set(10'h004);
    chk("irq masked", 32'(o_irq), 32'h0);
    rd(ndt_pkg::ADDR_IRQ_STAT, 32'h4);
    for (int k = 0; k < 14; k++) begin
      bus(1'b0, ndt_pkg::ADDR_CTRL, 32'(tbl[k][13:12]));
      line_set({1'b0, tbl[k][8:0]});
      chk("alarms", 32'(tx), 32'(tbl[k][11:9]));
      line_set(10'h000);
      chk("alarms cleared", 32'(tx), 32'h0);
    end
    rd(ndt_pkg::ADDR_IRQ_STAT, 32'h4);
    // A 2 ms burst of frames, a break, then frames for good: only the last run may activate.
    line_set(10'h200);
    repeat (50000) @(posedge i_clock);
    line_set(10'h000);
    chk("early activations", 32'(acts), 32'h0);
    @(posedge i_clock);
    cmd <= 10'h200;
    t0 = cyc;
    while (o_phys_activate_indication !== 1'b1 && cyc - t0 < 300000) @(posedge i_clock);
    chk("activation delay", 32'(cyc - t0 >= 225000 && cyc - t0 < 300000), 32'h1);
    rd(ndt_pkg::ADDR_IRQ_STAT, 32'h1);
    line_set(10'h000);
    repeat (75000) @(posedge i_clock);
    chk("deactivations on short break", 32'(deacts), 32'h0);
    chk("activations", 32'(acts), 32'h1);
    rd(ndt_pkg::ADDR_STATE, 32'he00);
    // Frames return during the break: the block must stay disarming while the activation timer runs.
    line_set(10'h200);
    repeat (50000) @(posedge i_clock);
    rd(ndt_pkg::ADDR_STATE, 32'h600);
    results();
  end
endmodule
